/* File: pkg/gim_pkg.sv */
// Purpose: Constants and carrier types for the port interrupt and mode-select block.
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses within the port's register window.
package gim_pkg;

  localparam int          PIN_COUNT         = 8;
  localparam int          ADDR_WIDTH        = 12;

  // Register byte offsets.
  localparam logic [11:0] OFS_DIRECTION     = 12'h400;
  localparam logic [11:0] OFS_SENSE_SELECT  = 12'h404;
  localparam logic [11:0] OFS_DUAL_EDGE     = 12'h408;
  localparam logic [11:0] OFS_POLARITY      = 12'h40C;
  localparam logic [11:0] OFS_MASK          = 12'h410;
  localparam logic [11:0] OFS_RAW_STATE     = 12'h414;
  localparam logic [11:0] OFS_MASKED_STATE  = 12'h418;
  localparam logic [11:0] OFS_CLEAR         = 12'h41C;
  localparam logic [11:0] OFS_ALT_FUNCTION  = 12'h420;

  // Reset values.
  localparam logic [7:0]  RST_ZERO          = 8'h00;
  localparam logic [7:0]  RST_ALT_PORT_B    = 8'h80;
  localparam logic [7:0]  RST_ALT_PORT_C    = 8'h0F;
  localparam logic [7:0]  RST_ALT_OTHER     = 8'h00;

  // Converter trigger pin position on port B.
  localparam int          TRIGGER_PIN       = 4;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Port identity selects the alternate-function reset default.
  typedef enum logic [1:0]
  {
    PORT_OTHER,
    PORT_B,
    PORT_C
  } gim_port_type;

  // Per-pin configuration carried together.
  typedef struct packed
  {
    logic [7:0] sense_select;
    logic [7:0] dual_edge_bits;
    logic [7:0] polarity_bits;
    logic [7:0] mask_enable_bits;
  } gim_cfg_type;

  // Write-side state of the register bus.
  typedef enum logic [1:0]
  {
    WR_IDLE,
    WR_RESP
  } gim_wr_state_type;

endpackage : gim_pkg

/* File: src/gim_port.sv */
// Purpose: Pin interrupt detection, mode selection and converter trigger for an 8-pin port.
// Assumes: Pin inputs are synchronous to MCLK_IN; one clock, asynchronous active-high reset.
// Notes:   Registers are reached over AXI4-Lite; the raw state and masked state are read-only.
// Operation
// R01: Sense-select 1 detects level, 0 detects edge.
// R02: Dual-edge setting acts on edge-sensed pins only.
// R03: Dual-edge 1 on edge pin: both transitions interrupt, polarity ignored.
// R04: Dual-edge 0: detect the single edge or level polarity selects.
// R05: Polarity 1 means rising or high; 0 means falling or low.
// R06: Mask-enable 1 lets the pin drive its own and the combined interrupt.
// R07: Mask-enable 0 blocks interrupts; raw state still recorded.
// R08: Raw state bits 7:0 show each met trigger condition regardless of masking.
// R09: Masked state is raw state AND mask-enable.
// R10: Writing 1 to clear register clears the edge latch; 0 does nothing; stateless.
// R11: Reset zeroes dual-edge, polarity, mask and raw state; clear reads zero.
// R12: Alternate-function 1 hands pin to peripheral; 0 keeps software control.
// R13: Alternate-function resets to 0x80 port B, 0x0F port C, else 0x00.
// R14: Any reset restores default direction and function of all pins.
// R15: After reset non-debug pins are inputs with alternate-function zero.
// R16: Unmasked port B pin 4 interrupt pulses the converter trigger.
// R17: Bits 31:8 read indeterminate; software writes them back unchanged.
// R18: Combined interrupt is high while any masked state bit is one.
// R19: Level-sensed raw state follows the level; clearing cannot hold it off.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module gim_port
  import gim_pkg::*;
#(
  parameter gim_port_type PORT_ID = PORT_OTHER
)
(
  // Clock and reset.
  input  wire logic                  MCLK_IN,
  input  wire logic                  RESET_IN,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_WIDTH-1:0] S_AXI_AWADDR_IN,
  input  wire logic                  S_AXI_AWVALID_IN,
  output logic                       S_AXI_AWREADY_OUT,
  input  wire logic [31:0]           S_AXI_WDATA_IN,
  input  wire logic [3:0]            S_AXI_WSTRB_IN,
  input  wire logic                  S_AXI_WVALID_IN,
  output logic                       S_AXI_WREADY_OUT,
  // AXI4-Lite write response.
  output logic [1:0]                 S_AXI_BRESP_OUT,
  output logic                       S_AXI_BVALID_OUT,
  input  wire logic                  S_AXI_BREADY_IN,
  // AXI4-Lite read.
  input  wire logic [ADDR_WIDTH-1:0] S_AXI_ARADDR_IN,
  input  wire logic                  S_AXI_ARVALID_IN,
  output logic                       S_AXI_ARREADY_OUT,
  output logic [31:0]                S_AXI_RDATA_OUT,
  output logic [1:0]                 S_AXI_RRESP_OUT,
  output logic                       S_AXI_RVALID_OUT,
  input  wire logic                  S_AXI_RREADY_IN,
  // Port pins.
  input  wire logic [7:0]            PIN_IN,
  // Pin control toward the pads and peripheral muxes.
  output logic [7:0]                 DIRECTION_OUT,
  output logic [7:0]                 ALT_FUNCTION_OUT,
  // Interrupts and converter trigger.
  output logic [7:0]                 PIN_IRQ_OUT,
  output logic                       COMBINED_PORT_IRQ_OUT,
  output logic                       CONVERTER_TRIGGER_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // The alternate-function default depends on which port this instance is.
  function automatic logic [7:0] alt_reset_value(input gim_port_type port_id);
    case (port_id)
      PORT_B:  alt_reset_value = RST_ALT_PORT_B;
      PORT_C:  alt_reset_value = RST_ALT_PORT_C;
      default: alt_reset_value = RST_ALT_OTHER;
    endcase
  endfunction : alt_reset_value

  // Byte-lane merge; only the low lane holds state.
  function automatic logic [7:0] lane_merge(input logic [7:0] old_value,
                                            input logic [31:0] wdata,
                                            input logic [3:0] wstrb);
    lane_merge = wstrb[0] ? wdata[7:0] : old_value;
  endfunction : lane_merge

  localparam logic [7:0] ALT_RESET = alt_reset_value(PORT_ID);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  gim_cfg_type      cfg_q;
  logic [7:0]       direction_q;
  logic [7:0]       alt_function_q;
  logic [7:0]       edge_latch_q;
  logic [7:0]       pin_prev_q;
  logic [7:0]       raw_state_bits;
  logic [7:0]       masked_state_bits;
  logic [7:0]       edge_event;
  logic [7:0]       level_hit;
  logic [7:0]       edge_latch_clear_bits;
  logic             trigger_prev_q;
  logic             trigger_q;

  gim_wr_state_type wr_state_q;
  logic             aw_held_q;
  logic             w_held_q;
  logic [11:0]      awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             wr_fire;
  logic             wr_known;
  logic [1:0]       bresp_q;
  logic             bvalid_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;
  logic [7:0]       rd_byte;
  logic             rd_known;

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order.

  assign S_AXI_AWREADY_OUT = (wr_state_q == WR_IDLE) && !aw_held_q;
  assign S_AXI_WREADY_OUT  = (wr_state_q == WR_IDLE) && !w_held_q;
  assign wr_fire           = (wr_state_q == WR_IDLE) && aw_held_q && w_held_q;

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR_IN;
      end
      else if (wr_fire)
      begin
        aw_held_q <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA_IN;
        wstrb_q  <= S_AXI_WSTRB_IN;
      end
      else if (wr_fire)
      begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_comb
  begin
    case ({awaddr_q[11:2], 2'b00})
      OFS_DIRECTION, OFS_SENSE_SELECT, OFS_DUAL_EDGE, OFS_POLARITY, OFS_MASK,
      OFS_RAW_STATE, OFS_MASKED_STATE, OFS_CLEAR, OFS_ALT_FUNCTION:
        wr_known = 1'b1;
      default:
        wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      wr_state_q <= WR_IDLE;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
    end
    else
    begin
      case (wr_state_q)
        WR_IDLE:
        begin
          if (wr_fire)
          begin
            wr_state_q <= WR_RESP;
            bvalid_q   <= 1'b1;
            bresp_q    <= wr_known ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP:
        begin
          if (S_AXI_BREADY_IN)
          begin
            wr_state_q <= WR_IDLE;
            bvalid_q   <= 1'b0;
          end
        end
        default:
        begin
          wr_state_q <= WR_IDLE;
          bvalid_q   <= 1'b0;
        end
      endcase
    end
  end

  assign S_AXI_BVALID_OUT = bvalid_q;
  assign S_AXI_BRESP_OUT  = bresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      cfg_q          <= '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO}; // see R11
      direction_q    <= RST_ZERO;                                  // see R15
      alt_function_q <= ALT_RESET;                                 // see R13 see R14
    end
    else if (wr_fire)
    begin
      case ({awaddr_q[11:2], 2'b00})
        OFS_DIRECTION:    direction_q <= lane_merge(direction_q, wdata_q, wstrb_q);
        OFS_SENSE_SELECT:
          cfg_q.sense_select <= lane_merge(cfg_q.sense_select, wdata_q, wstrb_q);
        OFS_DUAL_EDGE:
          cfg_q.dual_edge_bits <= lane_merge(cfg_q.dual_edge_bits, wdata_q, wstrb_q);
        OFS_POLARITY:
          cfg_q.polarity_bits <= lane_merge(cfg_q.polarity_bits, wdata_q, wstrb_q);
        OFS_MASK:
          cfg_q.mask_enable_bits <= lane_merge(cfg_q.mask_enable_bits, wdata_q, wstrb_q);
        OFS_ALT_FUNCTION:
          alt_function_q <= lane_merge(alt_function_q, wdata_q, wstrb_q); // see R12
        default:
        begin
        end
      endcase
    end
  end

  assign DIRECTION_OUT    = direction_q;
  assign ALT_FUNCTION_OUT = alt_function_q; // see R12

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt detection.

  // The clear register holds no state; a write is a one-cycle pulse per pin.
  assign edge_latch_clear_bits = (wr_fire && wstrb_q[0] && ({awaddr_q[11:2], 2'b00} == OFS_CLEAR))
                                 ? wdata_q[7:0] : 8'h00; // see R10

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      pin_prev_q <= RST_ZERO;
    end
    else
    begin
      pin_prev_q <= PIN_IN;
    end
  end

  // Both edges when dual-edge is set, else the one that polarity picks.
  assign edge_event = cfg_q.dual_edge_bits & (PIN_IN ^ pin_prev_q)               // see R03
                    | ~cfg_q.dual_edge_bits & cfg_q.polarity_bits & PIN_IN & ~pin_prev_q
                    | ~cfg_q.dual_edge_bits & ~cfg_q.polarity_bits & ~PIN_IN & pin_prev_q;
                                                                                 // see R04 R05
  assign level_hit = ~(PIN_IN ^ cfg_q.polarity_bits);                            // see R05

  // A new edge in the clearing cycle wins, so no event is lost.
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      edge_latch_q <= RST_ZERO; // see R11
    end
    else
    begin
      edge_latch_q <= (edge_latch_q & ~edge_latch_clear_bits) | (edge_event & ~cfg_q.sense_select);
                                                                                 // see R10 R02
    end
  end

  // Level pins bypass the latch, so a clear cannot hold them off.
  assign raw_state_bits    = (cfg_q.sense_select & level_hit)
                           | (~cfg_q.sense_select & edge_latch_q); // see R01 R08 R19
  assign masked_state_bits = raw_state_bits & cfg_q.mask_enable_bits; // see R09 R07

  assign PIN_IRQ_OUT           = masked_state_bits;  // see R06
  assign COMBINED_PORT_IRQ_OUT = |masked_state_bits; // see R18

  ////////////////////////////////////////////////////////////////////////////////
  // Converter trigger, port B instance only: one-cycle pulse on each rise of pin 4's unmasked interrupt.

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      trigger_prev_q <= 1'b0;
      trigger_q      <= 1'b0;
    end
    else
    begin
      trigger_prev_q <= masked_state_bits[TRIGGER_PIN];
      trigger_q      <= (PORT_ID == PORT_B) && masked_state_bits[TRIGGER_PIN] && !trigger_prev_q;
                                                                                 // see R16
    end
  end

  assign CONVERTER_TRIGGER_OUT = trigger_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel. Upper bits read as zero, one choice of the indeterminate value.

  always_comb
  begin
    rd_known = 1'b1;
    case ({S_AXI_ARADDR_IN[11:2], 2'b00})
      OFS_DIRECTION:    rd_byte = direction_q;
      OFS_SENSE_SELECT: rd_byte = cfg_q.sense_select;
      OFS_DUAL_EDGE:    rd_byte = cfg_q.dual_edge_bits;
      OFS_POLARITY:     rd_byte = cfg_q.polarity_bits;
      OFS_MASK:         rd_byte = cfg_q.mask_enable_bits;
      OFS_RAW_STATE:    rd_byte = raw_state_bits;    // see R08
      OFS_MASKED_STATE: rd_byte = masked_state_bits; // see R09
      OFS_CLEAR:        rd_byte = RST_ZERO;          // see R11
      OFS_ALT_FUNCTION: rd_byte = alt_function_q;
      default:
      begin
        rd_byte  = RST_ZERO;
        rd_known = 1'b0;
      end
    endcase
  end

  assign S_AXI_ARREADY_OUT = !rvalid_q;

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID_IN && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte}; // see R17
      rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && S_AXI_RREADY_IN)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_RVALID_OUT = rvalid_q;
  assign S_AXI_RDATA_OUT  = rdata_q;
  assign S_AXI_RRESP_OUT  = rresp_q;

endmodule : gim_port

`default_nettype wire

/* File: testbench/gim_pin_model.sv */
// Purpose: Drives the eight port pins as an outside circuit would.
// Assumes: Levels change just after a rising clock edge.
// Notes:   The slow setting adds one cycle of lag to every pin change.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module gim_pin_model
(
  // Clock.
  input  wire logic       clk_in,
  // Requested levels and pace.
  input  wire logic [7:0] level_in,
  input  wire logic       slow_in,
  // Pin levels.
  output logic      [7:0] pin_out
);
  logic [7:0] stage_q;

  // Pins are registered so they never move in the sampling step of the block.
  always_ff @(posedge clk_in)
  begin
    stage_q <= level_in;
    pin_out <= slow_in ? stage_q : level_in;
  end
endmodule : gim_pin_model
`default_nettype wire

/* File: testbench/gim_port_monitor.sv */
// Purpose: Port-level checks of the interrupt and mode-select block.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to every gim_port instance.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module gim_port_monitor
  import gim_pkg::*;
#(
  parameter gim_port_type PORT_ID = PORT_OTHER
)
(
  input wire logic        MCLK_IN,
  input wire logic        RESET_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic [7:0]  DIRECTION_OUT,
  input wire logic [7:0]  ALT_FUNCTION_OUT,
  input wire logic [7:0]  PIN_IRQ_OUT,
  input wire logic        COMBINED_PORT_IRQ_OUT,
  input wire logic        CONVERTER_TRIGGER_OUT
);
  localparam logic [7:0] ALT_RST = (PORT_ID == PORT_B) ? RST_ALT_PORT_B :
                                   (PORT_ID == PORT_C) ? RST_ALT_PORT_C : RST_ALT_OTHER;

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);

  property p_comb_irq; COMBINED_PORT_IRQ_OUT == (|PIN_IRQ_OUT); endproperty
  a_comb_irq: assert property (p_comb_irq)
    else $error("combined interrupt differs from pin interrupts");
  // Only the port B instance owns the converter trigger.
  property p_trig_cause;
    (PORT_ID == PORT_B) && $rose(PIN_IRQ_OUT[TRIGGER_PIN]) |=> CONVERTER_TRIGGER_OUT;
  endproperty
  a_trig_cause: assert property (p_trig_cause)
    else $error("converter trigger missing");
  property p_trig_only;
    CONVERTER_TRIGGER_OUT |-> $past(PIN_IRQ_OUT[TRIGGER_PIN]) && !$past(PIN_IRQ_OUT[TRIGGER_PIN], 2);
  endproperty
  a_trig_only: assert property (p_trig_only)
    else $error("converter trigger without a new pin interrupt");
  // Checked at the first edge after release, since bus traffic may follow at once.
  property p_reset_pins; $fell(RESET_IN) |-> ALT_FUNCTION_OUT == ALT_RST && DIRECTION_OUT == 8'h00;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pin control not at default after reset");
  property p_reset_irq; $fell(RESET_IN) |-> PIN_IRQ_OUT == 8'h00 && !CONVERTER_TRIGGER_OUT; endproperty
  a_reset_irq: assert property (p_reset_irq)
    else $error("interrupt active after reset");
  property p_read_ans; S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT; endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read answer late");
  property p_b_drop; S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT; endproperty
  a_b_drop: assert property (p_b_drop)
    else $error("write response repeated");
  property p_r_drop; S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT; endproperty
  a_r_drop: assert property (p_r_drop)
    else $error("read answer repeated");
  property p_upper_zero; S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000; endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");

  c_trigger: cover property (CONVERTER_TRIGGER_OUT);
  c_irq: cover property ($rose(COMBINED_PORT_IRQ_OUT));
  c_slverr: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == RESP_SLVERR);
endmodule : gim_port_monitor

bind gim_port gim_port_monitor #(.PORT_ID(PORT_ID)) gim_port_monitor_i
(
  .MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
  .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
  .S_AXI_BREADY_IN(S_AXI_BREADY_IN), .DIRECTION_OUT(DIRECTION_OUT),
  .ALT_FUNCTION_OUT(ALT_FUNCTION_OUT), .PIN_IRQ_OUT(PIN_IRQ_OUT),
  .COMBINED_PORT_IRQ_OUT(COMBINED_PORT_IRQ_OUT), .CONVERTER_TRIGGER_OUT(CONVERTER_TRIGGER_OUT)
);
`default_nettype wire

/* File: testbench/gim_port_test.sv */
// Purpose: Self-checking bench of the interrupt and mode-select block on port B.
// Assumes: Bus answers are matched to expectations in issue order.
// Notes:   A second reset at the end of the run checks that defaults return.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module gim_port_test import gim_pkg::*; ;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, comb_irq, trig, slow, hit;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  pins, level, dir, alt, pin_irq, bit_p, a;
  logic [3:0]  md;
  logic [3:0]  modes [8] = '{4'b0011, 4'b0010, 4'b0000, 4'b0101, 4'b0110, 4'b1011, 4'b1101, 4'b1000};
  logic [33:0] exp_q [$];
  string       name_q [$];
  int          errors, checks_done, cycles, trig_seen, trig_exp, p;

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  gim_pin_model gim_pin_model_i (.clk_in(clk), .level_in(level), .slow_in(slow), .pin_out(pins));
  gim_port #(.PORT_ID(PORT_B)) gim_port_i
  (
    .MCLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .PIN_IN(pins), .DIRECTION_OUT(dir), .ALT_FUNCTION_OUT(alt), .PIN_IRQ_OUT(pin_irq),
    .COMBINED_PORT_IRQ_OUT(comb_irq), .CONVERTER_TRIGGER_OUT(trig)
  );

  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] want);
    checks_done++;
    if (seen !== want)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Answers are compared where they appear, against the oldest note.
  always @(posedge clk)
  begin
    cycles++;
    if (trig === 1'b1) trig_seen++;
    if (rvalid === 1'b1 && rready === 1'b1) chk(name_q.pop_front(), {rresp, rdata}, exp_q.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) chk(name_q.pop_front(), {bresp, 32'h0}, exp_q.pop_front());
    // A hung handshake ends the run here, so the tasks wait without a limit of their own.
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  // Handshakes are sampled at the falling edge, where no input or state moves.
  task automatic wr(input logic [11:0] ad, input logic [7:0] d, input logic [1:0] resp);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'b0;
    exp_q.push_back({resp, 32'h0});
    name_q.push_back("write response");
    awaddr <= ad;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs)
    begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    // One edge passes before the next call may raise bready again.
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [7:0] d, input string what);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    exp_q.push_back({RESP_OKAY, 24'h000000, d});
    name_q.push_back(what);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs)
    begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic defaults;
    logic [11:0] ofs [9] = '{OFS_DIRECTION, OFS_SENSE_SELECT, OFS_DUAL_EDGE, OFS_POLARITY,
                             OFS_MASK, OFS_RAW_STATE, OFS_MASKED_STATE, OFS_CLEAR, OFS_ALT_FUNCTION};
    foreach (ofs[i]) rd(ofs[i], (i == 8) ? RST_ALT_PORT_B : RST_ZERO, "reset value");
    @(negedge clk);
    chk("pin control", {18'h0, alt, dir}, {18'h0, RST_ALT_PORT_B, RST_ZERO});
    @(posedge clk);
  endtask : defaults

  initial
  begin
    {rst, level, slow, awvalid, wvalid, bready, arvalid, rready} = {1'b1, 14'h0000};
    {awaddr, araddr, wdata} = 56'h0;
    void'($urandom(54));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    defaults();
    a = 8'($urandom);
    wr(OFS_ALT_FUNCTION, a, RESP_OKAY);
    wr(OFS_DIRECTION, ~a, RESP_OKAY);
    wr(12'h7F0, 8'hFF, RESP_SLVERR);
    rd(OFS_ALT_FUNCTION, a, "alternate function");
    rd(OFS_DIRECTION, ~a, "direction");
    for (int m = 0; m < 8; m++)
    begin
      md = modes[m];
      p = (m == 0) ? TRIGGER_PIN : $urandom_range(7);
      bit_p = 8'h01 << p;
      hit = (!md[3] && md[2]) || (md[1] == md[0]);
      slow <= m[0];
      level[p] <= !md[0];
      repeat (4) @(posedge clk);
      wr(OFS_SENSE_SELECT, md[3] ? bit_p : 8'h00, RESP_OKAY);
      wr(OFS_DUAL_EDGE, md[2] ? bit_p : 8'h00, RESP_OKAY);
      wr(OFS_POLARITY, md[1] ? bit_p : 8'h00, RESP_OKAY);
      wr(OFS_CLEAR, 8'hFF, RESP_OKAY);
      rd(OFS_CLEAR, 8'h00, "clear readback");
      level[p] <= md[0];
      repeat (5) @(posedge clk);
      rd(OFS_RAW_STATE, hit ? bit_p : 8'h00, "raw state");
      rd(OFS_MASKED_STATE, 8'h00, "masked state");
      wr(OFS_MASK, bit_p, RESP_OKAY);
      rd(OFS_MASKED_STATE, hit ? bit_p : 8'h00, "masked state");
      @(negedge clk);
      chk("pin interrupts", {26'h0, pin_irq}, {26'h0, hit ? bit_p : 8'h00});
      chk("combined interrupt", {33'h0, comb_irq}, {33'h0, hit});
      @(posedge clk);
      trig_exp += (p == TRIGGER_PIN && hit);
      wr(OFS_CLEAR, ~bit_p, RESP_OKAY);
      rd(OFS_RAW_STATE, hit ? bit_p : 8'h00, "raw state");
      wr(OFS_CLEAR, bit_p, RESP_OKAY);
      rd(OFS_RAW_STATE, (hit && md[3]) ? bit_p : 8'h00, "raw state");
      wr(OFS_MASK, 8'h00, RESP_OKAY);
    end
    chk("trigger pulses", trig_seen, trig_exp);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    defaults();
    stop_test();
  end
endmodule : gim_port_test
`default_nettype wire
